//--- hdl/pwm_pkg.sv
// register map, field positions and reset values for the two-channel pwm block
// assumes axi4-lite byte addresses of four times the index
package pwm_pkg;
    // register indices
    localparam logic [7:0] IDX_FLAGS_ONE    = 8'h0C;
    localparam logic [7:0] IDX_FLAGS_TWO    = 8'h0D;
    localparam logic [7:0] IDX_TIMER_COUNT  = 8'h11;
    localparam logic [7:0] IDX_TIMER_CTRL   = 8'h12;
    localparam logic [7:0] IDX_DUTY_LOW_1   = 8'h15;
    localparam logic [7:0] IDX_SHADOW_1     = 8'h16;
    localparam logic [7:0] IDX_CTRL_1       = 8'h17;
    localparam logic [7:0] IDX_DUTY_LOW_2   = 8'h1B;
    localparam logic [7:0] IDX_SHADOW_2     = 8'h1C;
    localparam logic [7:0] IDX_CTRL_2       = 8'h1D;
    localparam logic [7:0] IDX_ENABLES_ONE  = 8'h8C;
    localparam logic [7:0] IDX_ENABLES_TWO  = 8'h8D;
    localparam logic [7:0] IDX_PERIOD_LIMIT = 8'h92;
    // field positions
    localparam int CTRL_DUTY_LSB_POS = 4;
    localparam int CTRL_MODE_HI_POS  = 2;
    localparam int TCTRL_RUN_POS     = 2;
    localparam int TCTRL_PS_POS      = 0;
    localparam int TCTRL_POST_POS    = 3;
    localparam int FLAGS_T2_POS      = 1;
    // reset values and write masks
    localparam logic [7:0] RST_BYTE_ZERO   = 8'h00;
    localparam logic [7:0] RST_PERIOD      = 8'hFF;
    localparam logic [7:0] CTRL_WMASK      = 8'h3F;
    localparam logic [7:0] TCTRL_WMASK     = 8'h7F;
    localparam logic [7:0] FLAGS_TWO_WMASK = 8'h01;
    // axi responses and pwm mode code
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [1:0] MODE_PWM    = 2'b11;
endpackage : pwm_pkg

//--- hdl/pwm_tick_if.sv
// shared period timer state handed to each pwm channel
// assumes one timer drives all channels on the same clock
`timescale 1ns/10ps
interface pwm_tick_if;
    logic [9:0] base;      // timer count extended by two sub-count bits
    logic       wrap;      // one-cycle pulse: period complete
    modport timer (output base, output wrap);
    modport chan  (input base, input wrap);
endinterface : pwm_tick_if

//--- hdl/pwm_channel.sv
// one pwm channel: duty double buffer and output latch
// assumes the shared timer pulses wrap once per period
`timescale 1ns/10ps
module pwm_channel
    import pwm_pkg::*;
(
    input  wire logic       aclk,       // system clock
    input  wire logic       aresetn,    // sync reset, active low
    pwm_tick_if.chan        tick,       // shared time base
    input  wire logic [7:0] ctrl,       // channel control register
    input  wire logic [7:0] duty_low,   // duty low byte register
    output      logic [7:0] shadow,     // active duty high part
    output      logic       pwm_out     // output latch
);
    logic [1:0] shadow_lsb;
    logic [9:0] next_duty;
    logic       pwm_mode;
    logic       wrap_d;
    assign pwm_mode  = (ctrl[CTRL_MODE_HI_POS +: 2] == MODE_PWM);
    assign next_duty = {duty_low, ctrl[CTRL_DUTY_LSB_POS +: 2]};

    // ========================================
    // duty double buffer, loaded only at wrap
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shadow     <= RST_BYTE_ZERO;
            shadow_lsb <= 2'h0;
            wrap_d     <= 1'b0;
        end else begin
            wrap_d <= pwm_mode && tick.wrap;
            if (pwm_mode && tick.wrap) begin
                shadow     <= next_duty[9:2];
                shadow_lsb <= next_duty[1:0];
            end
        end
    end

    // ========================================
    // output latch; set wins one clock after wrap, clear on match
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_out <= 1'b0;
        end else if (ctrl == RST_BYTE_ZERO) begin
            pwm_out <= 1'b0;
        end else if (!pwm_mode) begin
            pwm_out <= 1'b0;
        end else if (wrap_d) begin
            // set lags wrap one clock: high time is exactly duty
            pwm_out <= ({shadow, shadow_lsb} != 10'h000);
        end else if ({shadow, shadow_lsb} == tick.base) begin
            pwm_out <= 1'b0;
        end
    end
endmodule : pwm_channel

//--- hdl/pwm_generator.sv
// two-channel pwm block with shared period timer and axi4-lite registers
// assumes a single aclk domain; port direction is set elsewhere by software
//
// Functional notes
// - pwm output with up to ten-bit duty resolution.
// - zero channel control forces the output latch low.
// - period is (limit + 1) * 4 clocks * prescale.
// - after count equals limit: clear timer, set pin unless duty zero, load duty.
// - postscaler never affects the period.
// - duty is low byte as msbs, two control bits as lsbs.
// - high time is duty * one clock * prescale.
// - duty writes take effect only at period end.
// - shadow is read-only in pwm mode.
// - shadow byte plus two-bit latch double-buffer the duty.
// - pin clears when shadow duty equals count plus two sub bits.
// - duty beyond period keeps the pin high.
// - prescaler divides by one, four or sixteen.
// - both channels share one period timer.
// - second channel mirrors the first, own registers.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module pwm_generator
    import pwm_pkg::*;
#(
    parameter int ADDR_W = 12  // axi address width
)(
    input  wire logic              aclk,          // system clock, 10 MHz
    input  wire logic              aresetn,       // sync reset, active low
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // write address
    input  wire logic              s_axi_awvalid, // write address valid
    output      logic              s_axi_awready, // write address ready
    input  wire logic [31:0]       s_axi_wdata,   // write data
    input  wire logic [3:0]        s_axi_wstrb,   // write strobes
    input  wire logic              s_axi_wvalid,  // write data valid
    output      logic              s_axi_wready,  // write data ready
    output      logic [1:0]        s_axi_bresp,   // write response
    output      logic              s_axi_bvalid,  // write response valid
    input  wire logic              s_axi_bready,  // write response ready
    input  wire logic [ADDR_W-1:0] s_axi_araddr,  // read address
    input  wire logic              s_axi_arvalid, // read address valid
    output      logic              s_axi_arready, // read address ready
    output      logic [31:0]       s_axi_rdata,   // read data
    output      logic [1:0]        s_axi_rresp,   // read response
    output      logic              s_axi_rvalid,  // read data valid
    input  wire logic              s_axi_rready,  // read data ready
    output      logic              pwm_channel_one_pin, // channel one output
    output      logic              pwm_channel_two      // channel two output
);
    if (ADDR_W < 10) begin : g_chk
        $error("ADDR_W too small for register map");
    end

    // ========================================
    // registers
    logic [7:0] peripheral_flags_one;
    logic [7:0] peripheral_flags_two;
    logic [7:0] period_timer_count;
    logic [7:0] period_timer_control;
    logic [7:0] duty_low_byte_one;
    logic [7:0] channel_control_one;
    logic [7:0] duty_low_byte_two;
    logic [7:0] channel_control_two;
    logic [7:0] peripheral_enables_one;
    logic [7:0] peripheral_enables_two;
    logic [7:0] period_limit;
    logic [7:0] duty_shadow_one;
    logic [7:0] duty_shadow_two;
    logic       pwm_one_q;
    logic       pwm_two_q;

    // ========================================
    // write channel: take address and data in either order
    logic [ADDR_W-1:0] aw_addr;
    logic              aw_held;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              w_held;
    logic              do_write;
    logic [7:0]        w_idx;
    logic              w_hit;
    logic [7:0]        wbyte;

    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign w_idx    = 8'(aw_addr[ADDR_W-1:2]);
    assign wbyte    = w_data[7:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready;
            s_axi_wready  <= !w_held && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= w_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        unique case (w_idx)
            IDX_FLAGS_ONE, IDX_FLAGS_TWO, IDX_TIMER_COUNT, IDX_TIMER_CTRL,
            IDX_DUTY_LOW_1, IDX_SHADOW_1, IDX_CTRL_1, IDX_DUTY_LOW_2,
            IDX_SHADOW_2, IDX_CTRL_2, IDX_ENABLES_ONE, IDX_ENABLES_TWO,
            IDX_PERIOD_LIMIT: w_hit = (aw_addr[1:0] == 2'b00);
            default:          w_hit = 1'b0;
        endcase
    end

    logic wr_en;
    assign wr_en = do_write && w_hit && w_strb[0];

    // ========================================
    // software registers; shadows are never software-written
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_timer_control   <= RST_BYTE_ZERO;
            duty_low_byte_one      <= RST_BYTE_ZERO;
            channel_control_one    <= RST_BYTE_ZERO;
            duty_low_byte_two      <= RST_BYTE_ZERO;
            channel_control_two    <= RST_BYTE_ZERO;
            peripheral_enables_one <= RST_BYTE_ZERO;
            peripheral_enables_two <= RST_BYTE_ZERO;
            period_limit           <= RST_PERIOD;
            peripheral_flags_two   <= RST_BYTE_ZERO;
        end else if (wr_en) begin
            unique case (w_idx)
                IDX_TIMER_CTRL:   period_timer_control   <= wbyte & TCTRL_WMASK;
                IDX_DUTY_LOW_1:   duty_low_byte_one      <= wbyte;
                IDX_CTRL_1:       channel_control_one    <= wbyte & CTRL_WMASK;
                IDX_DUTY_LOW_2:   duty_low_byte_two      <= wbyte;
                IDX_CTRL_2:       channel_control_two    <= wbyte & CTRL_WMASK;
                IDX_ENABLES_ONE:  peripheral_enables_one <= wbyte;
                IDX_ENABLES_TWO:  peripheral_enables_two <= wbyte & FLAGS_TWO_WMASK;
                IDX_PERIOD_LIMIT: period_limit           <= wbyte;
                IDX_FLAGS_TWO:    peripheral_flags_two   <= wbyte & FLAGS_TWO_WMASK;
                default:          ;
            endcase
        end
    end

    // ========================================
    // shared period timer: prescaler 1/4/16 of the quarter-clock rate
    pwm_tick_if tick ();
    logic [1:0] qclk;
    logic [3:0] pre_cnt;
    logic [3:0] pre_max;
    logic       timer_run;
    logic       inc;
    logic [1:0] sub_bits;
    logic       match_seen;
    logic       timer_wr;

    assign timer_run = period_timer_control[TCTRL_RUN_POS];
    assign timer_wr  = wr_en && (w_idx == IDX_TIMER_COUNT);

    always_comb begin
        unique case (period_timer_control[TCTRL_PS_POS +: 2])
            2'b00:   pre_max = 4'h0;
            2'b01:   pre_max = 4'h3;
            default: pre_max = 4'hF;
        endcase
    end

    // one timer step each four clocks times prescale; postscale bits unused
    assign inc = timer_run && (qclk == 2'b11) && (pre_cnt == pre_max);
    // sub-count: quarter clock at prescale 1, low two prescaler bits at 4, top two at 16
    assign sub_bits = (pre_max == 4'h0) ? qclk :
                      (pre_max == 4'h3) ? pre_cnt[1:0] : pre_cnt[3:2];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            qclk    <= 2'b00;
            pre_cnt <= 4'h0;
        end else if (!timer_run) begin
            qclk    <= 2'b00;
            pre_cnt <= 4'h0;
        end else begin
            qclk <= qclk + 2'b01;
            if (qclk == 2'b11) begin
                pre_cnt <= (pre_cnt == pre_max) ? 4'h0 : pre_cnt + 4'h1;
            end
        end
    end

    // equal to limit flags the next increment as the wrap
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_timer_count <= RST_BYTE_ZERO;
            match_seen         <= 1'b0;
        end else if (timer_wr) begin
            period_timer_count <= wbyte;
            match_seen         <= 1'b0;
        end else if (inc) begin
            match_seen         <= 1'b0;
            period_timer_count <= match_seen ? RST_BYTE_ZERO : period_timer_count + 8'h01;
            if (!match_seen && (period_timer_count + 8'h01 == period_limit)) begin
                match_seen <= 1'b1;
            end
        end else if (period_timer_count == period_limit) begin
            match_seen <= 1'b1;
        end
    end

    // base: timer count with the sub-count below it
    logic [1:0] sub_bits_adj;
    assign sub_bits_adj = sub_bits;
    assign tick.wrap = inc && match_seen;
    assign tick.base = {period_timer_count, sub_bits_adj};

    // period flag: set wins over a software clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            peripheral_flags_one <= RST_BYTE_ZERO;
        end else begin
            if (wr_en && (w_idx == IDX_FLAGS_ONE)) begin
                peripheral_flags_one <= wbyte;
            end
            if (tick.wrap) begin
                peripheral_flags_one[FLAGS_T2_POS] <= 1'b1;
            end
        end
    end

    // ========================================
    // channels
    pwm_channel u_chan_one (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .tick     (tick.chan),
        .ctrl     (channel_control_one),
        .duty_low (duty_low_byte_one),
        .shadow   (duty_shadow_one),
        .pwm_out  (pwm_one_q)
    );

    pwm_channel u_chan_two (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .tick     (tick.chan),
        .ctrl     (channel_control_two),
        .duty_low (duty_low_byte_two),
        .shadow   (duty_shadow_two),
        .pwm_out  (pwm_two_q)
    );

    assign pwm_channel_one_pin = pwm_one_q;
    assign pwm_channel_two     = pwm_two_q;

    // ========================================
    // read channel: one-cycle registered answer
    logic [7:0] r_idx;
    logic [7:0] r_byte;
    logic       r_hit;
    assign r_idx = 8'(s_axi_araddr[ADDR_W-1:2]);

    always_comb begin
        r_hit = (s_axi_araddr[1:0] == 2'b00);
        unique case (r_idx)
            IDX_FLAGS_ONE:    r_byte = peripheral_flags_one;
            IDX_FLAGS_TWO:    r_byte = peripheral_flags_two;
            IDX_TIMER_COUNT:  r_byte = period_timer_count;
            IDX_TIMER_CTRL:   r_byte = period_timer_control;
            IDX_DUTY_LOW_1:   r_byte = duty_low_byte_one;
            IDX_SHADOW_1:     r_byte = duty_shadow_one;
            IDX_CTRL_1:       r_byte = channel_control_one;
            IDX_DUTY_LOW_2:   r_byte = duty_low_byte_two;
            IDX_SHADOW_2:     r_byte = duty_shadow_two;
            IDX_CTRL_2:       r_byte = channel_control_two;
            IDX_ENABLES_ONE:  r_byte = peripheral_enables_one;
            IDX_ENABLES_TWO:  r_byte = peripheral_enables_two;
            IDX_PERIOD_LIMIT: r_byte = period_limit;
            default: begin
                r_byte = RST_BYTE_ZERO;
                r_hit  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {24'h000000, r_byte};
                s_axi_rresp   <= r_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : pwm_generator

//--- bench/pwm_generator_assertions.sv
// checker for the pwm block, bound to its top-level ports
// assumes one aclk domain and the package register indices
`timescale 1ns/10ps
module pwm_generator_assertions
    import pwm_pkg::*;
#(
    parameter int ADDR_W = 12  // address width
)(
    input wire logic              aclk,                // clock
    input wire logic              aresetn,             // reset, low
    input wire logic [ADDR_W-1:0] s_axi_awaddr,        // aw addr
    input wire logic              s_axi_awvalid,       // aw valid
    input wire logic              s_axi_awready,       // aw ready
    input wire logic [31:0]       s_axi_wdata,         // w data
    input wire logic              s_axi_wvalid,        // w valid
    input wire logic              s_axi_wready,        // w ready
    input wire logic [1:0]        s_axi_bresp,         // b resp
    input wire logic              s_axi_bvalid,        // b valid
    input wire logic              s_axi_bready,        // b ready
    input wire logic              s_axi_arvalid,       // ar valid
    input wire logic              s_axi_arready,       // ar ready
    input wire logic [31:0]       s_axi_rdata,         // r data
    input wire logic [1:0]        s_axi_rresp,         // r resp
    input wire logic              s_axi_rvalid,        // r valid
    input wire logic              s_axi_rready,        // r ready
    input wire logic              pwm_channel_one_pin, // pin one
    input wire logic              pwm_channel_two      // pin two
);
    logic [7:0] aw_idx;
    logic [7:0] w_byte;
    logic       wr_busy;
    logic [1:0] ctrl_on;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========================================
    // mode tracking, gated while a write is in flight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_idx  <= 8'h00;
            w_byte  <= 8'h00;
            wr_busy <= 1'b0;
            ctrl_on <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_idx  <= s_axi_awaddr[9:2];
                wr_busy <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_byte <= s_axi_wdata[7:0];
            end
            if (s_axi_bvalid && s_axi_bready) begin
                wr_busy <= 1'b0;
                if (s_axi_bresp == RESP_OKAY && aw_idx == IDX_CTRL_1) begin
                    ctrl_on[0] <= (w_byte[3:2] == MODE_PWM);
                end
                if (s_axi_bresp == RESP_OKAY && aw_idx == IDX_CTRL_2) begin
                    ctrl_on[1] <= (w_byte[3:2] == MODE_PWM);
                end
            end
        end
    end
    // ==========================================
    // assertions
    AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |-> ##1 s_axi_rvalid)
        else $error("read answer late");
    AST_RDATA_BYTE: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    AST_RD_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h00000000)
        else $error("error read returned data");
    AST_SHADOW_WR_OKAY: assert property (s_axi_bvalid && aw_idx == IDX_SHADOW_1 |-> s_axi_bresp == RESP_OKAY)
        else $error("shadow write refused");
    AST_CTRL1_OFF_LOW: assert property (!ctrl_on[0] && !wr_busy |=> !pwm_channel_one_pin)
        else $error("channel one high while off");
    AST_CTRL2_OFF_LOW: assert property (!ctrl_on[1] && !wr_busy |=> !pwm_channel_two)
        else $error("channel two high while off");
endmodule : pwm_generator_assertions

//--- bench/pwm_load.sv
// external load on one pwm pin: measures high time and period
// assumes the pin is a clean flip-flop level on aclk
`timescale 1ns/10ps
module pwm_load (
    input  wire logic        aclk,     // clock
    input  wire logic        aresetn,  // reset, low
    input  wire logic        pin,      // pwm pin
    output      logic [15:0] high_len, // last high time
    output      logic [15:0] per_len,  // last period
    output      logic        meas      // pulse: new figures
);
    logic        prev;
    logic        seen;
    logic [15:0] cnt;
    logic [15:0] hi;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev     <= 1'b0;
            seen     <= 1'b0;
            cnt      <= 16'h0000;
            hi       <= 16'h0000;
            meas     <= 1'b0;
            high_len <= 16'h0000;
            per_len  <= 16'h0000;
        end else begin
            prev <= pin;
            meas <= 1'b0;
            if (pin && !prev) begin
                // first rise only starts counting, no full period yet
                meas     <= seen;
                seen     <= 1'b1;
                per_len  <= cnt;
                high_len <= hi;
                cnt      <= 16'h0001;
                hi       <= 16'h0001;
            end else begin
                cnt <= cnt + 16'h0001;
                hi  <= hi + {15'h0000, pin};
            end
        end
    end
endmodule : pwm_load

//--- bench/testbench.sv
// self-checking bench: axi master tasks, two pin loads, queued expectations
// assumes design, loads and checker compiled first
`timescale 1ns/10ps
module testbench;
    import pwm_pkg::*;
    localparam int AW = 12;
    logic          aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic          awready, wready, bvalid, arready, rvalid;
    logic [AW-1:0] awaddr, araddr;
    logic [31:0]   wdata, rdata, seed;
    logic [3:0]    wstrb;
    logic [1:0]    bresp, rresp, pin, mv;
    logic [15:0]   hl [2];
    logic [15:0]   pl [2];
    logic [9:0]    d2;
    int            mismatches, checks, f;
    logic [1:0]    bq[$];
    logic [33:0]   rq[$];
    logic [31:0]   pq0[$], pq1[$];
    pwm_generator #(.ADDR_W(AW)) pwm_generator_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pwm_channel_one_pin(pin[0]), .pwm_channel_two(pin[1]));
    for (genvar c = 0; c < 2; c++) begin : load
        pwm_load pwm_load_i (.aclk(aclk), .aresetn(aresetn), .pin(pin[c]), .high_len(hl[c]), .per_len(pl[c]),
            .meas(mv[c]));
    end
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    // ==========================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [33:0] ok(input logic [7:0] b);
        return {RESP_OKAY, 24'h000000, b};
    endfunction : ok
    task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] idx, input logic [7:0] val, input logic [1:0] exp);
        bq.push_back(exp);
        awaddr  <= {2'h0, idx, 2'h0};
        wdata   <= {24'h000000, val};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] idx, input logic [33:0] exp);
        rq.push_back(exp);
        araddr  <= {2'h0, idx, 2'h0};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    // first period after a change is mixed, so it is skipped
    task automatic expect_pwm(input int ch, input logic [15:0] hi, input logic [15:0] per);
        do @(posedge aclk); while (!mv[ch]);
        @(negedge aclk);
        if (ch == 0) pq0.push_back({hi, per});
        else pq1.push_back({hi, per});
        do @(posedge aclk); while (!mv[ch]);
    endtask : expect_pwm
    task automatic hold(input logic lvl);
        int bad = 0;
        repeat (150) @(posedge aclk);
        repeat (200) begin
            @(negedge aclk);
            if (pin[0] !== lvl) bad++;
        end
        cmp(34'(bad), 34'h000000000);
    endtask : hold
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    // ==========================================
    // monitor: oldest note against each result
    always @(posedge aclk) begin
        if (bvalid && bready && bq.size() > 0) cmp(34'(bresp), 34'(bq.pop_front()));
        if (rvalid && rready && rq.size() > 0) cmp({rresp, rdata}, rq.pop_front());
        if (mv[0] && pq0.size() > 0) cmp({2'h0, hl[0], pl[0]}, {2'h0, pq0.pop_front()});
        if (mv[1] && pq1.size() > 0) cmp({2'h0, hl[1], pl[1]}, {2'h0, pq1.pop_front()});
    end
    initial begin
        repeat (40000) @(posedge aclk);
        mismatches++;
        test_done();
    end
    // ==========================================
    // main sequence
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        mismatches = 0;
        checks = 0;
        seed = 32'h00010411;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(IDX_PERIOD_LIMIT, ok(RST_PERIOD));
        rd(IDX_CTRL_1, ok(8'h00));
        rd(IDX_TIMER_CTRL, ok(8'h00));
        rd(8'h01, {RESP_SLVERR, 32'h00000000});
        wr(8'h01, 8'h55, RESP_SLVERR);
        seed = lfsr(lfsr(seed));
        d2 = 10'(seed % 39) + 10'h001;
        wr(IDX_PERIOD_LIMIT, 8'h09, RESP_OKAY);
        wr(IDX_DUTY_LOW_1, 8'h05, RESP_OKAY);
        wr(IDX_DUTY_LOW_2, d2[9:2], RESP_OKAY);
        wr(IDX_TIMER_CTRL, 8'h7C, RESP_OKAY);
        wr(IDX_CTRL_1, 8'h2C, RESP_OKAY);
        wr(IDX_CTRL_2, {2'h0, d2[1:0], 4'hF}, RESP_OKAY);
        for (int i = 0; i < 3; i++) begin
            f = 1 << (2 * i);
            wr(IDX_TIMER_CTRL, 8'h7C | 8'(i), RESP_OKAY);
            expect_pwm(0, 16'(22 * f), 16'(40 * f));
            expect_pwm(1, 16'(d2 * f), 16'(40 * f));
        end
        wr(IDX_SHADOW_1, 8'hAA, RESP_OKAY);
        wr(IDX_DUTY_LOW_1, 8'h07, RESP_OKAY);
        rd(IDX_SHADOW_1, ok(8'h05));
        expect_pwm(0, 16'(30 * 16), 16'(640));
        rd(IDX_SHADOW_1, ok(8'h07));
        rd(IDX_FLAGS_ONE, ok(8'h02));
        wr(IDX_TIMER_CTRL, 8'h7C, RESP_OKAY);
        wr(IDX_DUTY_LOW_1, 8'hFF, RESP_OKAY);
        hold(1'b1);
        wr(IDX_CTRL_1, 8'h00, RESP_OKAY);
        hold(1'b0);
        wr(IDX_DUTY_LOW_1, 8'h00, RESP_OKAY);
        wr(IDX_CTRL_1, 8'hCC, RESP_OKAY);
        hold(1'b0);
        rd(IDX_CTRL_1, ok(8'h0C));
        test_done();
    end
endmodule : testbench

bind pwm_generator pwm_generator_assertions #(.ADDR_W(ADDR_W)) pwm_generator_assertions_i (.*);
